//--- logic/pmc_pkg.sv
package pmc_pkg;
  // register offsets
  localparam logic [15:0] RX_GAIN_OFS   = 16'h040D;
  localparam logic [15:0] GEN_CFG_OFS   = 16'h0456;
  localparam logic [15:0] PIN_OVR_OFS   = 16'h0459;
  localparam logic [15:0] PIN_DIR_OFS   = 16'h045A;
  localparam logic [15:0] IND_CFG_OFS   = 16'h0460;
  // reset values
  localparam logic [15:0] RX_GAIN_RST   = 16'h0000;
  localparam logic [15:0] GEN_CFG_RST   = 16'h0008;
  localparam logic [15:0] PIN_OVR_RST   = 16'h0000;
  localparam logic [15:0] PIN_DIR_RST   = 16'h0000;
  localparam logic [15:0] IND_CFG_RST   = 16'h0650;
  // writable bit masks, everything else reads zero
  localparam logic [15:0] RX_GAIN_MASK  = 16'h001F;
  localparam logic [15:0] GEN_CFG_MASK  = 16'h2008;
  localparam logic [15:0] PIN_OVR_MASK  = 16'h0001;
  localparam logic [15:0] PIN_DIR_MASK  = 16'h0001;
  localparam logic [15:0] IND_CFG_MASK  = 16'h0FF0;
  // field positions
  localparam int          LINK_FAIL_BIT = 13;
  localparam int          SHORT_GAP_BIT = 3;
  localparam int          DIR_OVR_BIT   = 0;
  localparam int          DIR_VAL_BIT   = 0;
  localparam int          IND3_LSB      = 8;
  localparam int          IND3_W        = 4;
  localparam logic [3:0]  IND3_RST_SEL  = 4'h6;
  // receive threshold in millivolts
  localparam logic [9:0]  GAIN_BASE_MV  = 10'h0C8;
  localparam logic [9:0]  GAIN_STEP_MV  = 10'h019;
  localparam logic [9:0]  GAIN_MAX_MV   = 10'h23F;
  // timing
  localparam int          CLK_PERIOD_NS = 25;
  localparam int          SHORT_GAP_NS  = 120;
  localparam int          LONG_GAP_NS   = 200;
  localparam int          SHORT_GAP_CYC = (SHORT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          LONG_GAP_CYC  = (LONG_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RX_ERR_EXT_CYC = 32;
  // indicator source codes
  typedef enum logic [3:0] {
    SRC_LINK = 4'h0, SRC_ACT = 4'h1, SRC_TX = 4'h2, SRC_RX = 4'h3,
    SRC_COL = 4'h4, SRC_SPD100 = 4'h5, SRC_SPD10 = 4'h6, SRC_FDX = 4'h7,
    SRC_BLINK = 4'h8, SRC_STRETCH = 4'h9, SRC_MII100FD = 4'hA, SRC_LPI = 4'hB,
    SRC_MIIERR = 4'hC, SRC_LOST = 4'hD, SRC_PRBS = 4'hE, SRC_RSVD = 4'hF
  } pmc_src_e;
  typedef enum logic [1:0] {
    EXT_IDLE = 2'h1,
    EXT_HOLD = 2'h2
  } pmc_ext_e;
endpackage

//--- logic/pmc_top.sv
// Local design decision: strobed register access.
`timescale 1ns/100ps
// Overview of operation
// - 5-bit gain code sets threshold 200mV plus 25mV per step, up to 575mV.
// - with link-fail bit 13 set, link loss holds receive error high 32 cycles.
// - short-gap bit 3 resets to one; one gives 120ns gap, zero 200ns.
// - override enable zero keeps default pin direction; one forces it by value bit.
// - override value zero makes pin output, one makes it input, when enabled.
// - third indicator source comes from field bits 11-8 in extended pin mode.
// - in plain pin mode the source field has no effect.
// - codes 0-4 select link, activity, transmit, receive, collision.
// - 5 high at 100M, 6 high at 10M and reset choice, 7 full duplex.
// - 8 link with activity blink, 9 stretched activity.
// - A lights at 100M full duplex, B shows low-power idle.
// - C lights on MII errors; F reserved.
// - D latches on link loss until plain_pin_mode status register is read.
// - E latches on any test pattern error until the error counter clears.
module pmc_top #(
  parameter int BLINK_CYCLES   = 2000000,
  parameter int STRETCH_CYCLES = 2000000
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        link_up,
  input  wire logic        speed_100,
  input  wire logic        full_duplex,
  input  wire logic        tx_act,
  input  wire logic        rx_act,
  input  wire logic        collision,
  input  wire logic        lpi_active,
  input  wire logic        mii_tx_err,
  input  wire logic        rx_err_in,
  input  wire logic        prbs_err,
  input  wire logic        prbs_cnt_clr,
  input  wire logic        plain_pin_mode_status_read,
  input  wire logic        extended_pin_mode,
  input  wire logic        tx_frame_end,
  input  wire logic        refclk_src,
  input  wire logic        refclk_in,
  output logic             mii_rx_err,
  output logic             tx_gap_hold,
  output logic      [4:0]  ten_base_rx_gain_code,
  output logic      [9:0]  rx_threshold_mv,
  output logic             reference_clock_output,
  output logic             reference_clock_oe,
  output logic             refclk_sampled,
  output logic             third_indicator
);
  logic [15:0] rx_gain_reg;
  logic [15:0] gen_cfg;
  logic [15:0] pin_ovr;
  logic [15:0] pin_dir;
  logic [15:0] ind_cfg;
  logic        link_d;
  logic        link_fall;
  pmc_pkg::pmc_ext_e ext_state;
  logic [5:0]  ext_cnt;
  logic [3:0]  gap_cnt;
  logic        link_lost;
  logic        prbs_seen;
  logic [31:0] blink_cnt;
  logic        blink_phase;
  logic [31:0] stretch_cnt;
  logic [3:0]  ind_sel;
  logic        next_ind;
  logic        next_oe;
  logic [9:0]  next_mv;
  logic [5:0]  err_run;

  assign link_fall = link_d & ~link_up;

  // register writes, masked so reserved bits never change
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_gain_reg <= pmc_pkg::RX_GAIN_RST;
      gen_cfg     <= pmc_pkg::GEN_CFG_RST;
      pin_ovr     <= pmc_pkg::PIN_OVR_RST;
      pin_dir     <= pmc_pkg::PIN_DIR_RST;
      ind_cfg     <= pmc_pkg::IND_CFG_RST;
    end else if (reg_wr) begin
      if (reg_addr == pmc_pkg::RX_GAIN_OFS) begin
        rx_gain_reg <= reg_wdata & pmc_pkg::RX_GAIN_MASK;
      end else if (reg_addr == pmc_pkg::GEN_CFG_OFS) begin
        gen_cfg <= reg_wdata & pmc_pkg::GEN_CFG_MASK;
      end else if (reg_addr == pmc_pkg::PIN_OVR_OFS) begin
        pin_ovr <= reg_wdata & pmc_pkg::PIN_OVR_MASK;
      end else if (reg_addr == pmc_pkg::PIN_DIR_OFS) begin
        pin_dir <= reg_wdata & pmc_pkg::PIN_DIR_MASK;
      end else if (reg_addr == pmc_pkg::IND_CFG_OFS) begin
        ind_cfg <= reg_wdata & pmc_pkg::IND_CFG_MASK;
      end
    end
  end

  // read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (!reg_rd) begin
      reg_rdata <= 16'h0000;
    end else if (reg_addr == pmc_pkg::RX_GAIN_OFS) begin
      reg_rdata <= rx_gain_reg;
    end else if (reg_addr == pmc_pkg::GEN_CFG_OFS) begin
      reg_rdata <= gen_cfg;
    end else if (reg_addr == pmc_pkg::PIN_OVR_OFS) begin
      reg_rdata <= pin_ovr;
    end else if (reg_addr == pmc_pkg::PIN_DIR_OFS) begin
      reg_rdata <= pin_dir;
    end else if (reg_addr == pmc_pkg::IND_CFG_OFS) begin
      reg_rdata <= ind_cfg;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // codes past 15 would exceed the comparator range, so they clamp at the top
  always_comb begin
    next_mv = pmc_pkg::GAIN_BASE_MV + 10'(rx_gain_reg[4:0]) * pmc_pkg::GAIN_STEP_MV;
    if (next_mv > pmc_pkg::GAIN_MAX_MV) begin
      next_mv = pmc_pkg::GAIN_MAX_MV;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ten_base_rx_gain_code <= 5'h00;
      rx_threshold_mv       <= pmc_pkg::GAIN_BASE_MV;
    end else begin
      ten_base_rx_gain_code <= rx_gain_reg[4:0];
      rx_threshold_mv       <= next_mv;
    end
  end

  // link-fail extension of the receive error line
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      link_d    <= 1'b0;
      ext_state <= pmc_pkg::EXT_IDLE;
      ext_cnt   <= 6'h00;
    end else begin
      link_d <= link_up;
      case (ext_state)
        pmc_pkg::EXT_IDLE: begin
          if (link_fall && gen_cfg[pmc_pkg::LINK_FAIL_BIT]) begin
            ext_state <= pmc_pkg::EXT_HOLD;
            ext_cnt   <= 6'(pmc_pkg::RX_ERR_EXT_CYC - 1);
          end
        end
        pmc_pkg::EXT_HOLD: begin
          if (ext_cnt == 6'h00) begin
            ext_state <= pmc_pkg::EXT_IDLE;
          end else begin
            ext_cnt <= ext_cnt - 6'h01;
          end
        end
        default: ext_state <= pmc_pkg::EXT_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mii_rx_err <= 1'b0;
    end else begin
      mii_rx_err <= rx_err_in | (ext_state == pmc_pkg::EXT_HOLD);
    end
  end

  // inter-packet gap: hold off the transmitter after each frame end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_cnt     <= 4'h0;
      tx_gap_hold <= 1'b0;
    end else begin
      if (tx_frame_end) begin
        gap_cnt <= gen_cfg[pmc_pkg::SHORT_GAP_BIT] ? 4'(pmc_pkg::SHORT_GAP_CYC - 1)
                                                   : 4'(pmc_pkg::LONG_GAP_CYC - 1);
        tx_gap_hold <= 1'b1;
      end else if (gap_cnt != 4'h0) begin
        gap_cnt <= gap_cnt - 4'h1;
      end else begin
        tx_gap_hold <= 1'b0;
      end
    end
  end

  // reference clock pin: output by default
  always_comb begin
    if (pin_ovr[pmc_pkg::DIR_OVR_BIT]) begin
      next_oe = ~pin_dir[pmc_pkg::DIR_VAL_BIT];
    end else begin
      next_oe = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reference_clock_oe     <= 1'b1;
      reference_clock_output <= 1'b0;
      refclk_sampled         <= 1'b0;
    end else begin
      reference_clock_oe     <= next_oe;
      reference_clock_output <= refclk_src;
      refclk_sampled         <= next_oe ? 1'b0 : refclk_in;
    end
  end

  // sticky indicator sources; a set in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      link_lost <= 1'b0;
    end else if (link_fall) begin
      link_lost <= 1'b1;
    end else if (plain_pin_mode_status_read) begin
      link_lost <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prbs_seen <= 1'b0;
    end else if (prbs_err) begin
      prbs_seen <= 1'b1;
    end else if (prbs_cnt_clr) begin
      prbs_seen <= 1'b0;
    end
  end

  // blink timebase, free running
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      blink_cnt   <= 32'h0000_0000;
      blink_phase <= 1'b0;
    end else if (blink_cnt == 32'(BLINK_CYCLES - 1)) begin
      blink_cnt   <= 32'h0000_0000;
      blink_phase <= ~blink_phase;
    end else begin
      blink_cnt <= blink_cnt + 32'h0000_0001;
    end
  end

  // activity stretch, retriggered by each activity cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stretch_cnt <= 32'h0000_0000;
    end else if (tx_act || rx_act) begin
      stretch_cnt <= 32'(STRETCH_CYCLES);
    end else if (stretch_cnt != 32'h0000_0000) begin
      stretch_cnt <= stretch_cnt - 32'h0000_0001;
    end
  end

  // plain pin mode ignores the field and keeps the reset choice
  assign ind_sel = extended_pin_mode ? ind_cfg[pmc_pkg::IND3_LSB +: pmc_pkg::IND3_W]
                                     : pmc_pkg::IND3_RST_SEL;

  always_comb begin
    case (pmc_pkg::pmc_src_e'(ind_sel))
      pmc_pkg::SRC_LINK:     next_ind = link_up;
      pmc_pkg::SRC_ACT:      next_ind = tx_act | rx_act;
      pmc_pkg::SRC_TX:       next_ind = tx_act;
      pmc_pkg::SRC_RX:       next_ind = rx_act;
      pmc_pkg::SRC_COL:      next_ind = collision;
      pmc_pkg::SRC_SPD100:   next_ind = link_up & speed_100;
      pmc_pkg::SRC_SPD10:    next_ind = link_up & ~speed_100;
      pmc_pkg::SRC_FDX:      next_ind = link_up & full_duplex;
      pmc_pkg::SRC_BLINK: begin
        next_ind = link_up & ~((stretch_cnt != 32'h0000_0000) & blink_phase);
      end
      pmc_pkg::SRC_STRETCH:  next_ind = (stretch_cnt != 32'h0000_0000);
      pmc_pkg::SRC_MII100FD: next_ind = link_up & speed_100 & full_duplex;
      pmc_pkg::SRC_LPI:      next_ind = lpi_active;
      pmc_pkg::SRC_MIIERR:   next_ind = mii_tx_err | rx_err_in;
      pmc_pkg::SRC_LOST:     next_ind = link_lost;
      pmc_pkg::SRC_PRBS:     next_ind = prbs_seen;
      default:               next_ind = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      third_indicator <= 1'b0;
    end else begin
      third_indicator <= next_ind;
    end
  end

  a_gain_threshold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ##1 rx_threshold_mv == ((rx_gain_reg[4:0] > 5'h0F) ? pmc_pkg::GAIN_MAX_MV :
      10'(pmc_pkg::GAIN_BASE_MV + 10'(rx_gain_reg[4:0]) * pmc_pkg::GAIN_STEP_MV))
      || $changed(rx_gain_reg))
    else $error("receive threshold does not follow gain code");

  // run length of the receive error line, so the 32-cycle hold needs no long repetition
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      err_run <= 6'h00;
    end else if (!mii_rx_err) begin
      err_run <= 6'h00;
    end else if (err_run != 6'h3F) begin
      err_run <= err_run + 6'h01;
    end
  end

  a_rxerr_extend: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (link_fall && gen_cfg[pmc_pkg::LINK_FAIL_BIT] && ext_state == pmc_pkg::EXT_IDLE)
      |-> ##34 (err_run >= 6'h20))
    else $error("receive error not held for 32 cycles on link loss");

  a_rxerr_plain: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!gen_cfg[pmc_pkg::LINK_FAIL_BIT] && ext_state == pmc_pkg::EXT_IDLE && !rx_err_in)
      |=> !mii_rx_err)
    else $error("receive error raised without cause");

  a_gap_length: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (tx_frame_end && gen_cfg[pmc_pkg::SHORT_GAP_BIT])
      ##1 !tx_frame_end [*5] |=> !tx_gap_hold)
    else $error("short gap lasts longer than five cycles");

  a_gap_long: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (tx_frame_end && !gen_cfg[pmc_pkg::SHORT_GAP_BIT])
      |=> (tx_gap_hold || tx_frame_end) [*8])
    else $error("long gap shorter than eight cycles");

  a_pin_direction: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ##1 reference_clock_oe ==
      ($past(pin_ovr[pmc_pkg::DIR_OVR_BIT]) ? !$past(pin_dir[pmc_pkg::DIR_VAL_BIT]) : 1'b1))
    else $error("reference clock pin direction wrong");

  a_plain_mode: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!extended_pin_mode && !link_up) |=> !third_indicator)
    else $error("plain mode indicator lit without 10M link");

  a_lost_latch: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (link_fall && extended_pin_mode && ind_cfg[11:8] == 4'hD)
      ##1 (!plain_pin_mode_status_read && extended_pin_mode && ind_cfg[11:8] == 4'hD) [*3]
      |=> third_indicator)
    else $error("link lost indicator dropped before status read");

  a_prbs_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (prbs_cnt_clr && !prbs_err) |=> !prbs_seen)
    else $error("test pattern error latch not cleared");

  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (ind_cfg & ~pmc_pkg::IND_CFG_MASK) == 16'h0000 &&
    (gen_cfg & ~pmc_pkg::GEN_CFG_MASK) == 16'h0000)
    else $error("reserved bits hold ones");
endmodule

//--- tb/phy_misc_config_led_select_bench.sv
`timescale 1ns/100ps
module phy_misc_config_led_select_bench;
  logic        ref_clk, reset_n, reg_wr, reg_rd, rx_err_in, prbs_err, prbs_cnt_clr;
  logic        plain_pin_mode_status_read, extended_pin_mode, tx_frame_end, refclk_src, refclk_in;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic [7:0]  stim;
  logic        mii_rx_err, tx_gap_hold, reference_clock_output, reference_clock_oe;
  logic        refclk_sampled, third_indicator;
  logic [4:0]  ten_base_rx_gain_code;
  logic [9:0]  rx_threshold_mv;
  int          fail_count, n_compared, cycles, n;
  logic [31:0] seed = 32'h0000F132;
  logic [31:0] r;
  logic [15:0] mdl[5];
  logic [15:0] ofs[5] = '{pmc_pkg::RX_GAIN_OFS, pmc_pkg::GEN_CFG_OFS, pmc_pkg::PIN_OVR_OFS,
                          pmc_pkg::PIN_DIR_OFS, pmc_pkg::IND_CFG_OFS};
  logic [15:0] rst[5] = '{pmc_pkg::RX_GAIN_RST, pmc_pkg::GEN_CFG_RST, pmc_pkg::PIN_OVR_RST,
                          pmc_pkg::PIN_DIR_RST, pmc_pkg::IND_CFG_RST};
  logic [15:0] msk[5] = '{pmc_pkg::RX_GAIN_MASK, pmc_pkg::GEN_CFG_MASK, pmc_pkg::PIN_OVR_MASK,
                          pmc_pkg::PIN_DIR_MASK, pmc_pkg::IND_CFG_MASK};
  logic [3:0]  codes[12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hA, 4'hB,
                             4'hC, 4'hF};
  logic [3:0]  c;
  logic [15:0] e;

  // stim packs {link, speed100, fdx, tx, rx, col, lpi, txerr}
  pmc_top #(.BLINK_CYCLES(8), .STRETCH_CYCLES(8)) DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_up(stim[7]),
    .speed_100(stim[6]), .full_duplex(stim[5]), .tx_act(stim[4]), .rx_act(stim[3]),
    .collision(stim[2]), .lpi_active(stim[1]), .mii_tx_err(stim[0]), .rx_err_in(rx_err_in),
    .prbs_err(prbs_err), .prbs_cnt_clr(prbs_cnt_clr), .plain_pin_mode_status_read(plain_pin_mode_status_read),
    .extended_pin_mode(extended_pin_mode), .tx_frame_end(tx_frame_end),
    .refclk_src(refclk_src), .refclk_in(refclk_in), .mii_rx_err(mii_rx_err),
    .tx_gap_hold(tx_gap_hold), .ten_base_rx_gain_code(ten_base_rx_gain_code),
    .rx_threshold_mv(rx_threshold_mv), .reference_clock_output(reference_clock_output),
    .reference_clock_oe(reference_clock_oe), .refclk_sampled(refclk_sampled),
    .third_indicator(third_indicator));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int idx(input logic [15:0] a);
    for (int i = 0; i < 5; i++) if (ofs[i] === a) return i;
    return -1;
  endfunction

  // reference indicator for the sources that have no memory
  function automatic logic ind_exp(input logic [3:0] cd, input logic [7:0] s);
    case (cd)
      4'h0: return s[7];
      4'h1: return s[4] | s[3];
      4'h2: return s[4];
      4'h3: return s[3];
      4'h4: return s[2];
      4'h5: return s[7] & s[6];
      4'h6: return s[7] & ~s[6];
      4'h7: return s[7] & s[5];
      4'hA: return s[7] & s[6] & s[5];
      4'hB: return s[1];
      4'hC: return s[0];
      default: return 1'b0;
    endcase
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    if (idx(a) >= 0) mdl[idx(a)] = d & msk[idx(a)];
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, (idx(a) < 0) ? 16'h0000 : mdl[idx(a)]);
  endtask

  // counts high cycles of the gap hold (w=0) or the receive error (w=1)
  task automatic cnt(input int w, output int k);
    k = 0;
    #1;
    repeat (60) begin
      if (((w == 0) ? tx_gap_hold : mii_rx_err) === 1'b1) k++;
      @(posedge ref_clk);
      #1;
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // generous ceiling: the sequence needs about 1200 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    {reset_n, reg_wr, reg_rd, rx_err_in, prbs_err, prbs_cnt_clr, plain_pin_mode_status_read} = '0;
    {tx_frame_end, refclk_src, refclk_in, stim, reg_addr, reg_wdata} = '0;
    extended_pin_mode = 1'b1;
    for (int i = 0; i < 5; i++) mdl[i] = rst[i];
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 5; i++) rd(ofs[i]);
    rd(16'h0404);
    rd(16'h0461);
    for (int i = 0; i < 5; i++) begin
      wr(ofs[i], 16'hFFFF);
      rd(ofs[i]);
      wr(ofs[i], 16'h0000);
      rd(ofs[i]);
    end
    for (int g = 0; g < 32; g++) begin
      r = rnd();
      wr(pmc_pkg::RX_GAIN_OFS, {r[15:5], g[4:0]});
      cyc(3);
      chk({11'h000, ten_base_rx_gain_code}, {11'h000, g[4:0]});
      e = (g > 15) ? 16'h023F : 16'h00C8 + 16'(g * 25);
      chk({6'h00, rx_threshold_mv}, e);
    end
    for (int g = 0; g < 2; g++) begin
      wr(pmc_pkg::GEN_CFG_OFS, (g == 1) ? 16'h0008 : 16'h0000);
      cyc(3);
      @(posedge ref_clk) tx_frame_end <= 1'b1;
      @(posedge ref_clk) tx_frame_end <= 1'b0;
      cnt(0, n);
      chk(16'(n), (g == 1) ? 16'h0005 : 16'h0008);
    end
    for (int g = 0; g < 2; g++) begin
      wr(pmc_pkg::GEN_CFG_OFS, (g == 0) ? 16'h2008 : 16'h0008);
      @(posedge ref_clk) stim <= 8'h80;
      cyc(4);
      @(posedge ref_clk) stim <= 8'h00;
      cnt(1, n);
      chk(16'(n), (g == 0) ? 16'h0020 : 16'h0000);
    end
    @(posedge ref_clk) rx_err_in <= 1'b1;
    cyc(3);
    chk({15'h0000, mii_rx_err}, 16'h0001);
    @(posedge ref_clk) rx_err_in <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      wr(pmc_pkg::PIN_OVR_OFS, {r[15:1], k[0]});
      wr(pmc_pkg::PIN_DIR_OFS, {r[31:17], k[1]});
      @(posedge ref_clk);
      refclk_in  <= r[2];
      refclk_src <= r[3];
      cyc(4);
      chk({15'h0000, reference_clock_oe}, {15'h0000, ~(k[0] & k[1])});
      chk({15'h0000, refclk_sampled}, {15'h0000, k[0] & k[1] & r[2]});
      chk({15'h0000, reference_clock_output}, {15'h0000, r[3]});
    end
    for (int i = 0; i < 72; i++) begin
      r = rnd();
      c = codes[i % 12];
      if (i >= 48) extended_pin_mode <= 1'b0;
      wr(pmc_pkg::IND_CFG_OFS, {r[15:12], c, r[7:0]});
      if (c == 4'hA) r[23] = 1'b1;
      @(posedge ref_clk) stim <= r[23:16];
      cyc(3);
      e = {15'h0000, ind_exp((i >= 48) ? 4'h6 : c, r[23:16])};
      chk({15'h0000, third_indicator}, e);
    end
    extended_pin_mode <= 1'b1;
    wr(pmc_pkg::IND_CFG_OFS, 16'h0900);
    @(posedge ref_clk) stim <= 8'h00;
    cyc(20);
    chk({15'h0000, third_indicator}, 16'h0000);
    @(posedge ref_clk) stim <= 8'h10;
    @(posedge ref_clk) stim <= 8'h00;
    cyc(2);
    chk({15'h0000, third_indicator}, 16'h0001);
    cyc(30);
    chk({15'h0000, third_indicator}, 16'h0000);
    wr(pmc_pkg::IND_CFG_OFS, 16'h0800);
    @(posedge ref_clk) stim <= 8'h80;
    cyc(30);
    chk({15'h0000, third_indicator}, 16'h0001);
    // steady activity: the blink phase of 8 cycles keeps the indicator dark half the time
    @(posedge ref_clk) stim <= 8'h98;
    cyc(3);
    n = 0;
    repeat (32) begin
      if (third_indicator === 1'b0) n++;
      @(posedge ref_clk);
      #1;
    end
    chk(16'(n), 16'h0010);
    wr(pmc_pkg::IND_CFG_OFS, 16'h0D00);
    // earlier link drops left the latch set; clear it so the next drop is seen afresh
    @(posedge ref_clk) plain_pin_mode_status_read <= 1'b1;
    @(posedge ref_clk) plain_pin_mode_status_read <= 1'b0;
    cyc(3);
    chk({15'h0000, third_indicator}, 16'h0000);
    @(posedge ref_clk) stim <= 8'h00;
    cyc(4);
    chk({15'h0000, third_indicator}, 16'h0001);
    @(posedge ref_clk) stim <= 8'h80;
    cyc(6);
    chk({15'h0000, third_indicator}, 16'h0001);
    @(posedge ref_clk) plain_pin_mode_status_read <= 1'b1;
    @(posedge ref_clk) plain_pin_mode_status_read <= 1'b0;
    cyc(3);
    chk({15'h0000, third_indicator}, 16'h0000);
    wr(pmc_pkg::IND_CFG_OFS, 16'h0E00);
    cyc(3);
    chk({15'h0000, third_indicator}, 16'h0000);
    @(posedge ref_clk) prbs_err <= 1'b1;
    @(posedge ref_clk) prbs_err <= 1'b0;
    cyc(10);
    chk({15'h0000, third_indicator}, 16'h0001);
    @(posedge ref_clk) prbs_cnt_clr <= 1'b1;
    @(posedge ref_clk) prbs_cnt_clr <= 1'b0;
    cyc(3);
    chk({15'h0000, third_indicator}, 16'h0000);
    give_verdict();
  end
endmodule
